// ===== rtl/fmsf_framer.sv
// Field mill sentence framer: reading to serial ASCII sentence
// Assumes field_i is signed hundredths of kV/m, rotor window flags from tachometer logic
// What this block does
// - Send one sentence twenty times per second
// - Characters go 9600 baud, 8N1
// - Start with dollar, then polarity sign
// - Magnitude as two digits, period, two digits
// - Least digit is hundredths of kV/m
// - Saturate reading at plus or minus twenty
// - Comma then fault digit zero or one
// - Rotor fault follows speed window continuously
// - Asterisk then checksum as two hex characters
// - End with carriage return then line feed
`timescale 1ns/100ps
module fmsf_framer
  import fmsf_pkg::*;
#(
  parameter int unsigned SENTENCE_CYCLES = SENTENCE_DIV,
  parameter int unsigned BAUD_CYCLES = BAUD_DIV
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Measurement
  input wire logic signed [15:0] field_i,
  input wire logic rotor_too_fast_i,
  input wire logic rotor_too_slow_i,
  // Serial line, rotor fault and busy status
  output logic txd_o,
  output logic rotor_fault_o,
  output logic busy_o
);
  import fmsf_pkg::*;

  typedef enum logic [1:0] {
    FMSF_IDLE = 2'b00,
    FMSF_START = 2'b01,
    FMSF_DATA = 2'b10,
    FMSF_STOP = 2'b11
  } fmsf_state_e;

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    hex_char = (n < 4'hA) ? CH_ZERO + {4'h0, n} : CH_A_LESS10 + {4'h0, n};
  endfunction : hex_char

  function automatic logic [7:0] dig_char(input logic [3:0] n);
    dig_char = CH_ZERO + {4'h0, n};
  endfunction : dig_char

  logic [23:0] frame_cnt_q;
  logic frame_tick;
  logic [15:0] baud_cnt_q;
  logic baud_tick;
  fmsf_state_e state_q;
  logic [2:0] bit_q;
  logic [7:0] shift_q;
  logic [3:0] idx_q;
  logic active_q;
  logic neg_q;
  logic [3:0] d_tens_q;
  logic [3:0] d_ones_q;
  logic [3:0] d_tenth_q;
  logic [3:0] d_hund_q;
  logic fault_q;
  logic [7:0] csum_q;
  logic [7:0] cur_char;
  logic [10:0] mag;
  logic [15:0] abs_f;

  // Sentence pacing
  assign frame_tick = (frame_cnt_q == 24'(SENTENCE_CYCLES - 1));
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || frame_tick) begin
      frame_cnt_q <= 24'h00_0000;
    end else begin
      frame_cnt_q <= frame_cnt_q + 24'h00_0001;
    end
  end

  // Baud enable, restarted per character
  assign baud_tick = (baud_cnt_q == 16'(BAUD_CYCLES - 1));
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || baud_tick || state_q == FMSF_IDLE) begin
      baud_cnt_q <= 16'h0000;
    end else begin
      baud_cnt_q <= baud_cnt_q + 16'h0001;
    end
  end

  // Rotor supervision
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rotor_fault_o <= 1'b0;
    end else begin
      rotor_fault_o <= rotor_too_fast_i | rotor_too_slow_i;
    end
  end

  // Magnitude with clamp
  assign abs_f = field_i[15] ? 16'(-field_i) : field_i;
  assign mag = (abs_f > {5'h00, MAG_MAX}) ? MAG_MAX : abs_f[10:0];

  // Capture reading at sentence start
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      neg_q <= 1'b0;
      d_tens_q <= 4'h0;
      d_ones_q <= 4'h0;
      d_tenth_q <= 4'h0;
      d_hund_q <= 4'h0;
      fault_q <= 1'b0;
    end else if (frame_tick && !active_q) begin
      neg_q <= field_i[15];
      d_tens_q <= 4'(mag / 11'd1000);
      d_ones_q <= 4'((mag / 11'd100) % 11'd10);
      d_tenth_q <= 4'((mag / 11'd10) % 11'd10);
      d_hund_q <= 4'(mag % 11'd10);
      fault_q <= rotor_fault_o;
    end
  end

  // Character of the sentence by position
  always_comb begin
    case (idx_q)
      4'h0: cur_char = CH_DOLLAR;
      4'h1: cur_char = neg_q ? CH_MINUS : CH_PLUS;
      4'h2: cur_char = dig_char(d_tens_q);
      4'h3: cur_char = dig_char(d_ones_q);
      4'h4: cur_char = CH_DOT;
      4'h5: cur_char = dig_char(d_tenth_q);
      4'h6: cur_char = dig_char(d_hund_q);
      4'h7: cur_char = CH_COMMA;
      4'h8: cur_char = fault_q ? 8'h31 : CH_ZERO;
      4'h9: cur_char = CH_STAR;
      4'hA: cur_char = hex_char(csum_q[7:4]);
      4'hB: cur_char = hex_char(csum_q[3:0]);
      4'hC: cur_char = CH_CR;
      4'hD: cur_char = CH_LF;
      default: cur_char = CH_LF;
    endcase
  end

  // Checksum accumulation
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || (frame_tick && !active_q)) begin
      csum_q <= 8'h00;
    end else if (state_q == FMSF_IDLE && active_q && idx_q != 4'h0 && idx_q < POS_STAR) begin
      csum_q <= csum_q ^ cur_char;
    end
  end

  // Serializer and character walker
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_q <= FMSF_IDLE;
      txd_o <= 1'b1;
      bit_q <= 3'h0;
      shift_q <= 8'h00;
      idx_q <= 4'h0;
      active_q <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      case (state_q)
        FMSF_IDLE: begin
          txd_o <= 1'b1;
          if (frame_tick && !active_q) begin
            active_q <= 1'b1;
            idx_q <= 4'h0;
            busy_o <= 1'b1;
          end else if (active_q) begin
            if (idx_q > 4'(SENT_LEN)) begin
              active_q <= 1'b0;
              busy_o <= 1'b0;
            end else begin
              shift_q <= cur_char;
              state_q <= FMSF_START;
              txd_o <= 1'b0;
            end
          end
        end
        FMSF_START: begin
          if (baud_tick) begin
            txd_o <= shift_q[0];
            bit_q <= 3'h0;
            state_q <= FMSF_DATA;
          end
        end
        FMSF_DATA: begin
          if (baud_tick) begin
            if (bit_q == 3'(DATA_BITS - 1)) begin
              txd_o <= 1'b1;
              state_q <= FMSF_STOP;
            end else begin
              txd_o <= shift_q[bit_q + 3'h1];
              bit_q <= bit_q + 3'h1;
            end
          end
        end
        FMSF_STOP: begin
          if (baud_tick) begin
            idx_q <= idx_q + 4'h1;
            state_q <= FMSF_IDLE;
          end
        end
        default: state_q <= FMSF_IDLE;
      endcase
    end
  end

  // Helper counters for the timing checks
  localparam int unsigned SENT_BUSY = (SENT_LEN + 1) * (10 * BAUD_CYCLES + 1) + 1;
  logic [31:0] tick_gap_q;
  logic tick_seen_q;
  logic [31:0] busy_len_q;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      tick_gap_q <= 32'h0000_0000;
      tick_seen_q <= 1'b0;
    end else if (frame_tick) begin
      tick_gap_q <= 32'h0000_0000;
      tick_seen_q <= 1'b1;
    end else begin
      tick_gap_q <= tick_gap_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || !busy_o) begin
      busy_len_q <= 32'h0000_0000;
    end else begin
      busy_len_q <= busy_len_q + 32'h0000_0001;
    end
  end

  // Timing checks
  a_tick_spacing: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (frame_tick && tick_seen_q) |-> (tick_gap_q == 32'(SENTENCE_CYCLES - 1)))
    else $error("sentence spacing wrong");
  a_sentence_len: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    $fell(busy_o) |-> (busy_len_q == 32'(SENT_BUSY)))
    else $error("sentence length wrong");
  a_idle_high: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (state_q == FMSF_IDLE) |-> txd_o)
    else $error("line not idle high");

  // Character position checks
  a_dollar_first: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (state_q == FMSF_START && idx_q == 4'h0) |-> (shift_q == CH_DOLLAR))
    else $error("first character not start mark");
  a_sign_char: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (state_q == FMSF_START && idx_q == 4'h1) |-> (shift_q == CH_PLUS || shift_q == CH_MINUS))
    else $error("polarity character wrong");
  a_digit_chars: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (state_q == FMSF_START && (idx_q == 4'h2 || idx_q == 4'h3 || idx_q == 4'h5 || idx_q == 4'h6))
    |-> (shift_q >= CH_ZERO && shift_q <= 8'h39))
    else $error("magnitude digit not decimal");
  a_dot_pos: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (state_q == FMSF_START && idx_q == 4'h4) |-> (shift_q == CH_DOT))
    else $error("period misplaced");
  a_comma_pos: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (state_q == FMSF_START && idx_q == 4'h7) |-> (shift_q == CH_COMMA))
    else $error("comma misplaced");
  a_fault_digit: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (state_q == FMSF_START && idx_q == 4'h8) |-> (shift_q == CH_ZERO || shift_q == 8'h31))
    else $error("fault digit wrong");
  a_star_pos: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (state_q == FMSF_START && idx_q == POS_STAR) |-> (shift_q == CH_STAR))
    else $error("asterisk misplaced");
  a_hex_char: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (state_q == FMSF_START && (idx_q == 4'hA || idx_q == 4'hB))
    |-> ((shift_q >= CH_ZERO && shift_q <= 8'h39) || (shift_q >= 8'h41 && shift_q <= 8'h46)))
    else $error("checksum character not hex");
  a_cr_char: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (state_q == FMSF_START && idx_q == 4'hC) |-> (shift_q == CH_CR))
    else $error("carriage return misplaced");

  a_sentence_start: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (frame_tick && !active_q && state_q == FMSF_IDLE) |=> ##1 (txd_o == 1'b0))
    else $error("sentence did not start on tick");
  a_stop_level: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (state_q == FMSF_STOP) |-> txd_o)
    else $error("stop bit not high");
  a_mag_clamp: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    mag <= MAG_MAX)
    else $error("magnitude beyond clamp");
  a_fault_follow: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (rotor_too_fast_i || rotor_too_slow_i) |=> rotor_fault_o)
    else $error("rotor fault not raised");
  a_fault_clear: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !(rotor_too_fast_i || rotor_too_slow_i) |=> !rotor_fault_o)
    else $error("rotor fault not cleared");
  a_digit_range: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    d_ones_q <= 4'h9 && d_tenth_q <= 4'h9 && d_hund_q <= 4'h9 && d_tens_q <= 4'h2)
    else $error("digit out of range");
  a_start_bit_len: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    $rose(state_q == FMSF_START) |-> (!txd_o) [*8])
    else $error("start bit too short");
  a_crlf_order: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (state_q == FMSF_START && idx_q == 4'hD) |-> (shift_q == CH_LF))
    else $error("line feed out of order");
endmodule : fmsf_framer

// ===== rtl/fmsf_pkg.sv
// Constants for the field mill sentence framer
// Assumes a 10 MHz system clock
package fmsf_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned BAUD_RATE = 9600;
  localparam int unsigned BAUD_DIV = CLK_HZ / BAUD_RATE;
  localparam int unsigned SENTENCES_PER_S = 20;
  localparam int unsigned SENTENCE_DIV = CLK_HZ / SENTENCES_PER_S;
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned STOP_BITS = 1;
  localparam int unsigned SENT_LEN = 13;
  localparam logic [10:0] MAG_MAX = 11'h07_D0;
  localparam logic [7:0] CH_DOLLAR = 8'h24;
  localparam logic [7:0] CH_PLUS = 8'h2B;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_DOT = 8'h2E;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_STAR = 8'h2A;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_A_LESS10 = 8'h37;
  localparam logic [3:0] POS_STAR = 4'h9;
endpackage : fmsf_pkg

// ===== verification/fmsf_host_rx.sv
// Serial receiver in place of the optical adapter and host
// Assumes 8N1 at the package baud divider on the system clock
`timescale 1ns/100ps
module fmsf_host_rx
  import fmsf_pkg::*;
#(
  parameter int unsigned LOST_CYCLES = 200_000,
  parameter int unsigned BIT_CYCLES = BAUD_DIV
) (
  // Clock and line
  input wire logic mclk_i,
  input wire logic rxd_i,
  // Received byte
  output logic [7:0] byte_o,
  output logic frame_err_o,
  output logic strobe_o,
  output logic lost_o
);
  int unsigned idle_cnt = 0;
  initial begin
    {byte_o, frame_err_o, strobe_o} = '0;
    forever begin
      @(negedge rxd_i);
      repeat (BIT_CYCLES / 2) @(posedge mclk_i);
      for (int i = 0; i < DATA_BITS; i++) begin
        repeat (BIT_CYCLES) @(posedge mclk_i);
        byte_o[i] <= rxd_i;
      end
      repeat (BIT_CYCLES) @(posedge mclk_i);
      frame_err_o <= !rxd_i;
      strobe_o <= 1'h1;
      @(posedge mclk_i);
      strobe_o <= 1'h0;
    end
  end
  // Checksum never inspected, only line feeds restart the watch
  always @(posedge mclk_i) begin
    idle_cnt <= (strobe_o && byte_o == CH_LF) ? 0 : idle_cnt + 1;
  end
  assign lost_o = idle_cnt > LOST_CYCLES;
endmodule : fmsf_host_rx

// ===== verification/tb.sv
// Self-checking bench for the sentence framer
// Assumes a shortened sentence period and the serial receiver model
`timescale 1ns/100ps
module tb;
  import fmsf_pkg::*;
  localparam int unsigned SC = 2_000;
  localparam int unsigned BC = 10;
  logic mclk_i = 1'h0;
  logic sys_rst_i = 1'h1;
  logic signed [15:0] field_i = '0;
  logic too_fast = 1'h0;
  logic too_slow = 1'h0;
  logic txd, fault, busy, busy_q, strobe, ferr, lost;
  logic [7:0] rx_byte;
  int error_cnt = 0;
  int compares = 0;
  int unsigned cyc = 0;
  int unsigned last_rise = 0;
  always #50 mclk_i = ~mclk_i;
  fmsf_framer #(.SENTENCE_CYCLES(SC), .BAUD_CYCLES(BC)) i_dut (.mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .field_i(field_i), .rotor_too_fast_i(too_fast), .rotor_too_slow_i(too_slow),
    .txd_o(txd), .rotor_fault_o(fault), .busy_o(busy));
  fmsf_host_rx #(.LOST_CYCLES(3 * SC), .BIT_CYCLES(BC)) i_host (.mclk_i(mclk_i),
    .rxd_i(txd), .byte_o(rx_byte),
    .frame_err_o(ferr), .strobe_o(strobe), .lost_o(lost));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic complete_run();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  function automatic logic [7:0] hex(input logic [3:0] n);
    return (n < 4'hA) ? CH_ZERO + n : CH_A_LESS10 + n;
  endfunction : hex
  task automatic sentence(input logic signed [15:0] f, input logic fast, input logic slow);
    logic [7:0] e [14];
    logic [15:0] m;
    logic [7:0] cs;
    int n;
    field_i <= f;
    too_fast <= fast;
    too_slow <= slow;
    m = (f < 0) ? -f : f;
    if (m > MAG_MAX) m = MAG_MAX;
    e = '{CH_DOLLAR, (f < 0) ? CH_MINUS : CH_PLUS, 8'(CH_ZERO + m / 1000),
      8'(CH_ZERO + m / 100 % 10), CH_DOT, 8'(CH_ZERO + m / 10 % 10), 8'(CH_ZERO + m % 10),
      CH_COMMA, CH_ZERO + (fast | slow), CH_STAR, 8'h00, 8'h00, CH_CR, CH_LF};
    cs = '0;
    for (int i = 1; i < 9; i++) cs ^= e[i];
    e[10] = hex(cs[7:4]);
    e[11] = hex(cs[3:0]);
    for (int i = 0; i < 14; i++) begin
      n = 0;
      do @(posedge mclk_i); while (strobe !== 1'h1 && ++n < 4 * SC);
      check("sentence byte", e[i], rx_byte);
      check("stop bit", 0, ferr);
    end
    check("rotor fault", fast | slow, fault);
  endtask : sentence
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    busy_q <= busy;
    if (busy && !busy_q) begin
      if (last_rise != 0) check("sentence period", SC, cyc - last_rise);
      last_rise <= cyc;
    end
    if (cyc == 20_000) begin
      error_cnt++;
      complete_run();
    end
  end
  initial begin
    repeat (20) @(posedge mclk_i);
    check("idle line", 1, txd);
    sys_rst_i <= 1'h0;
    sentence(16'sh0021, 1'h0, 1'h0);
    sentence(-16'sh09C4, 1'h1, 1'h0);
    sentence(16'sh07D1, 1'h0, 1'h1);
    sentence(16'sh0000, 1'h0, 1'h0);
    check("signal lost", 0, lost);
    complete_run();
  end
endmodule : tb
